// ---- alu_pkg.sv ----
package alu_pkg;
   // ****************************************
   // Operation codes presented to the datapath
   // ****************************************
   typedef enum logic [2:0] {
      OP_IDLE      = 3'h0,
      OP_MUL       = 3'h1,
      OP_NEGATE    = 3'h2,
      OP_INV       = 3'h3,
      OP_BIT_COUNT = 3'h4,
      OP_BIT_IMM   = 3'h5,
      OP_CARRY_INV = 3'h6
   } op_t;

   // ****************************************
   // Timing and field constants
   // ****************************************
   localparam int           CLK_PERIOD_NS   = 10;
   localparam int           IDLE_CYCLES     = 3;
   localparam logic [1:0]   IDLE_LAST       = 2'h2;
   localparam logic [1:0]   CNT_ZERO        = 2'h0;
   localparam logic [1:0]   CNT_ONE         = 2'h1;
   localparam logic [3:0]   BYTE_IDX_MASK   = 4'h7;
   localparam logic [3:0]   WORD_IDX_MASK   = 4'hF;
   localparam logic [15:0]  WORD_ZERO       = 16'h0000;
   localparam logic [15:0]  WORD_ONE        = 16'h0001;
   localparam logic [15:0]  BYTE_MASK       = 16'h00FF;
   localparam logic [5:0]   FLAGS_RESET     = 6'h00;
   // Flag vector positions: aux carry, carry, overflow, parity, sign, zero.
   localparam int           F_AC    = 5;
   localparam int           F_CARRY = 4;
   localparam int           F_V     = 3;
   localparam int           F_P     = 2;
   localparam int           F_S     = 1;
   localparam int           F_Z     = 0;
endpackage

// ---- alu_if.sv ----
// ****************************************
// Operand and result bundle for the compute core
// ****************************************
interface alu_if;
   alu_pkg::op_t op;
   logic         word;
   logic [15:0]  acc;
   logic [15:0]  dst;
   logic [7:0]   count;
   logic [7:0]   imm;
   logic [5:0]   flags_in;
   logic [15:0]  res;
   logic [15:0]  ext;
   logic [5:0]   flags_out;
   logic         wr_dst;
   logic         wr_acc;
   logic         wr_ext;
   modport top (output op, word, acc, dst, count, imm, flags_in,
                input res, ext, flags_out, wr_dst, wr_acc, wr_ext);
   modport core (input op, word, acc, dst, count, imm, flags_in,
                 output res, ext, flags_out, wr_dst, wr_acc, wr_ext);
endinterface

// ---- alu_core.sv ----
// ****************************************
// Combinational compute core
// ****************************************
module alu_core (
   alu_if.core a
);
   logic [31:0] prod;
   logic [15:0] r;
   logic [15:0] msk;
   logic [3:0]  idx;

   // Parity counts the low byte only, as on every such core.
   function automatic logic parity8(input logic [7:0] v);
      return ~^v;
   endfunction

   always_comb begin
      msk         = a.word ? alu_pkg::WORD_ONE - alu_pkg::WORD_ONE - alu_pkg::WORD_ONE : alu_pkg::BYTE_MASK;
      prod        = 32'h0000_0000;
      r           = a.dst;
      idx         = 4'h0;
      a.res       = a.dst;
      a.ext       = alu_pkg::WORD_ZERO;
      a.flags_out = a.flags_in;
      a.wr_dst    = 1'b0;
      a.wr_acc    = 1'b0;
      a.wr_ext    = 1'b0;
      case (a.op)
         alu_pkg::OP_MUL: begin
            if (a.word) begin
               prod     = {16'h0000, a.acc} * {16'h0000, a.dst};
               a.res    = prod[15:0];
               a.ext    = prod[31:16];
               a.wr_ext = 1'b1;
               a.flags_out[alu_pkg::F_CARRY] = |prod[31:16];
               a.flags_out[alu_pkg::F_V]  = |prod[31:16];
            end else begin
               prod  = {24'h00_0000, a.acc[7:0]} * {24'h00_0000, a.dst[7:0]};
               a.res = prod[15:0];
               a.flags_out[alu_pkg::F_CARRY] = |prod[15:8];
               a.flags_out[alu_pkg::F_V]  = |prod[15:8];
            end
            a.wr_acc = 1'b1;
         end
         alu_pkg::OP_NEGATE: begin
            r        = (~a.dst + alu_pkg::WORD_ONE) & msk;
            a.res    = r;
            a.wr_dst = 1'b1;
            a.flags_out[alu_pkg::F_CARRY] = |(a.dst & msk);
            a.flags_out[alu_pkg::F_AC] = (a.dst[3:0] != 4'h0);
            a.flags_out[alu_pkg::F_V]  = a.word ? (a.dst == 16'h8000) : (a.dst[7:0] == 8'h80);
            a.flags_out[alu_pkg::F_P]  = parity8(r[7:0]);
            a.flags_out[alu_pkg::F_S]  = a.word ? r[15] : r[7];
            a.flags_out[alu_pkg::F_Z]  = (r == alu_pkg::WORD_ZERO);
         end
         alu_pkg::OP_INV: begin
            a.res    = ~a.dst & msk;
            a.wr_dst = 1'b1;
         end
         alu_pkg::OP_BIT_COUNT, alu_pkg::OP_BIT_IMM: begin
            idx      = (a.op == alu_pkg::OP_BIT_COUNT) ? a.count[3:0] : a.imm[3:0];
            idx      = idx & (a.word ? alu_pkg::WORD_IDX_MASK : alu_pkg::BYTE_IDX_MASK);
            a.res    = (a.dst ^ (alu_pkg::WORD_ONE << idx)) & msk;
            a.wr_dst = 1'b1;
         end
         alu_pkg::OP_CARRY_INV: begin
            a.flags_out[alu_pkg::F_CARRY] = ~a.flags_in[alu_pkg::F_CARRY];
         end
         default: begin
            a.res = a.dst;
         end
      endcase
   end
endmodule

// ---- alu_datapath.sv ----
// ****************************************
// Execution datapath top
// ****************************************
module alu_datapath (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         start,
   input  wire logic [2:0]   op,
   input  wire logic         word,
   input  wire logic [15:0]  acc_in,
   input  wire logic [15:0]  dst_in,
   input  wire logic [7:0]   count_in,
   input  wire logic [7:0]   imm_in,
   input  wire logic [5:0]   flags_in,
   output logic              busy,
   output logic              done,
   output logic [15:0]       result,
   output logic [15:0]       ext_out,
   output logic [5:0]        flags_out,
   output logic              wr_dst,
   output logic              wr_acc,
   output logic              wr_ext
);
   typedef enum logic [1:0] {
      ST_READY = 2'b00,
      ST_IDLE  = 2'b01
   } state_t;

   alu_if a ();
   alu_core u_core (
      .a (a)
   );

   logic         rst_s1_reg;
   logic         rst_s2_reg;
   state_t       state_reg;
   state_t       state_next;
   logic [1:0]   cnt_reg;
   logic [1:0]   cnt_next;
   logic         busy_reg;
   logic         busy_next;
   logic         done_reg;
   logic         done_next;
   logic [15:0]  result_reg;
   logic [15:0]  result_next;
   logic [15:0]  ext_reg;
   logic [15:0]  ext_next;
   logic [5:0]   flags_reg;
   logic [5:0]   flags_next;
   logic         wr_dst_reg;
   logic         wr_dst_next;
   logic         wr_acc_reg;
   logic         wr_acc_next;
   logic         wr_ext_reg;
   logic         wr_ext_next;

   // ****************************************
   // Reset release synchroniser
   // ****************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end

   // Operands go straight to the core; the caller holds them while start is high.
   assign a.op       = alu_pkg::op_t'(op);
   assign a.word     = word;
   assign a.acc      = acc_in;
   assign a.dst      = dst_in;
   assign a.count    = count_in;
   assign a.imm      = imm_in;
   assign a.flags_in = flags_in;

   // ****************************************
   // Sequencing and result capture
   // ****************************************
   // Every operation but the idle one answers one cycle after start. The idle
   // instruction keeps the unit busy so that it occupies three cycles in all.
   always_comb begin
      state_next  = state_reg;
      cnt_next    = cnt_reg;
      busy_next   = busy_reg;
      done_next   = 1'b0;
      result_next = result_reg;
      ext_next    = ext_reg;
      flags_next  = flags_reg;
      wr_dst_next = 1'b0;
      wr_acc_next = 1'b0;
      wr_ext_next = 1'b0;
      case (state_reg)
         ST_READY: begin
            if (start) begin
               if (a.op == alu_pkg::OP_IDLE) begin
                  state_next = ST_IDLE;
                  cnt_next   = alu_pkg::CNT_ONE;
                  busy_next  = 1'b1;
                  flags_next = flags_in;
               end else begin
                  done_next   = 1'b1;
                  result_next = a.res;
                  ext_next    = a.ext;
                  flags_next  = a.flags_out;
                  wr_dst_next = a.wr_dst;
                  wr_acc_next = a.wr_acc;
                  wr_ext_next = a.wr_ext;
               end
            end
         end
         ST_IDLE: begin
            cnt_next = cnt_reg + alu_pkg::CNT_ONE;
            if (cnt_reg == alu_pkg::IDLE_LAST) begin
               state_next = ST_READY;
               cnt_next   = alu_pkg::CNT_ZERO;
               busy_next  = 1'b0;
               done_next  = 1'b1;
            end
         end
         default: begin
            state_next = ST_READY;
            cnt_next   = alu_pkg::CNT_ZERO;
            busy_next  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_s2_reg) begin
      if (!rst_s2_reg) begin
         state_reg  <= ST_READY;
         cnt_reg    <= alu_pkg::CNT_ZERO;
         busy_reg   <= 1'b0;
         done_reg   <= 1'b0;
         result_reg <= alu_pkg::WORD_ZERO;
         ext_reg    <= alu_pkg::WORD_ZERO;
         flags_reg  <= alu_pkg::FLAGS_RESET;
         wr_dst_reg <= 1'b0;
         wr_acc_reg <= 1'b0;
         wr_ext_reg <= 1'b0;
      end else begin
         state_reg  <= state_next;
         cnt_reg    <= cnt_next;
         busy_reg   <= busy_next;
         done_reg   <= done_next;
         result_reg <= result_next;
         ext_reg    <= ext_next;
         flags_reg  <= flags_next;
         wr_dst_reg <= wr_dst_next;
         wr_acc_reg <= wr_acc_next;
         wr_ext_reg <= wr_ext_next;
      end
   end

   assign busy      = busy_reg;
   assign done      = done_reg;
   assign result    = result_reg;
   assign ext_out   = ext_reg;
   assign flags_out = flags_reg;
   assign wr_dst    = wr_dst_reg;
   assign wr_acc    = wr_acc_reg;
   assign wr_ext    = wr_ext_reg;
endmodule

// ---- alu_datapath_props.sv ----
module alu_datapath_props (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        start,
   input wire logic [2:0]  op,
   input wire logic        word,
   input wire logic [15:0] acc_in,
   input wire logic [15:0] dst_in,
   input wire logic [7:0]  count_in,
   input wire logic [7:0]  imm_in,
   input wire logic [5:0]  flags_in,
   input wire logic        busy,
   input wire logic        done,
   input wire logic [15:0] result,
   input wire logic [15:0] ext_out,
   input wire logic [5:0]  flags_out,
   input wire logic        wr_dst,
   input wire logic        wr_acc,
   input wire logic        wr_ext
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Accepted requests and their answers
   // ****************************************
   // A request only counts when the datapath is free; starts during busy are dropped.
   wire logic tk = start && !busy;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   chk_idle_three_cycles: assert property (tk && op == 3'h0 |=> busy && !done ##1 busy && !done ##1 !busy && done)
      else $error("idle instruction did not take three cycles");
   // The idle answer must carry the flags seen at start and write nothing at all.
   chk_idle_no_change: assert property (tk && op == 3'h0 |=> ##2 (flags_out == $past(flags_in, 3) &&
      !wr_dst && !wr_acc && !wr_ext)) else $error("idle instruction changed state");
   chk_mul_byte_prod: assert property (tk && op == 3'h1 && !word |=>
      result == {8'h00, $past(acc_in[7:0])} * {8'h00, $past(dst_in[7:0])}) else $error("byte product wrong");
   chk_mul_byte_flag: assert property (tk && op == 3'h1 && !word |=>
      flags_out[4] == (result[15:8] != 8'h00) && flags_out[3] == flags_out[4]) else $error("byte multiply flags wrong");
   chk_mul_word_prod: assert property (tk && op == 3'h1 && word |=>
      {ext_out, result} == 32'($past(acc_in)) * 32'($past(dst_in))) else $error("word product wrong");
   chk_mul_word_flag: assert property (tk && op == 3'h1 && word |=>
      flags_out[4] == (ext_out != 16'h0000) && flags_out[3] == flags_out[4]) else $error("word multiply flags wrong");
   chk_negate_value: assert property (tk && op == 3'h2 |=> result == ($past(word) ?
      16'h0000 - $past(dst_in) : {8'h00, 8'h00 - $past(dst_in[7:0])})) else $error("negate result wrong");
   chk_negate_carry: assert property (tk && op == 3'h2 |=> flags_out[4] == ($past(word) ?
      $past(dst_in) != 16'h0000 : $past(dst_in[7:0]) != 8'h00)) else $error("negate carry wrong");
   chk_inv_value: assert property (tk && op == 3'h3 |=> flags_out == $past(flags_in) && result ==
      ($past(word) ? ~$past(dst_in) : {8'h00, ~$past(dst_in[7:0])})) else $error("invert result wrong");
   chk_bit_count: assert property (tk && op == 3'h4 |=> result == ($past(word) ?
      $past(dst_in) ^ (16'h0001 << $past(count_in[3:0])) :
      {8'h00, $past(dst_in[7:0]) ^ (8'h01 << $past(count_in[2:0]))}))
      else $error("counted bit invert wrong");
   chk_bit_imm: assert property (tk && op == 3'h5 |=> result == ($past(word) ?
      $past(dst_in) ^ (16'h0001 << $past(imm_in[3:0])) :
      {8'h00, $past(dst_in[7:0]) ^ (8'h01 << $past(imm_in[2:0]))}))
      else $error("immediate bit invert wrong");
   chk_carry_inv: assert property (tk && op == 3'h6 |=> flags_out == ($past(flags_in) ^ 6'h10))
      else $error("carry invert wrong");
endmodule

bind alu_datapath alu_datapath_props props (.clk(clk), .rst_b(rst_b), .start(start), .op(op), .word(word),
   .acc_in(acc_in), .dst_in(dst_in), .count_in(count_in), .imm_in(imm_in), .flags_in(flags_in), .busy(busy),
   .done(done), .result(result), .ext_out(ext_out), .flags_out(flags_out), .wr_dst(wr_dst), .wr_acc(wr_acc),
   .wr_ext(wr_ext));

// ---- test_alu_datapath.sv ----
module test_alu_datapath;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        start = 1'b0;
   logic [2:0]  op = 3'h0;
   logic        word = 1'b0;
   logic [15:0] acc_in = 16'h0000;
   logic [15:0] dst_in = 16'h0000;
   logic [7:0]  count_in = 8'h00;
   logic [7:0]  imm_in = 8'h00;
   logic [5:0]  flags_in = 6'h00;
   logic        busy, done, wr_dst, wr_acc, wr_ext;
   logic [15:0] result, ext_out;
   logic [5:0]  flags_out;
   int          n_errors = 0;
   int          num_checks = 0;
   int          cycles = 0;
   alu_datapath dut (.clk(clk), .rst_b(rst_b), .start(start), .op(op), .word(word), .acc_in(acc_in),
      .dst_in(dst_in), .count_in(count_in), .imm_in(imm_in), .flags_in(flags_in), .busy(busy), .done(done),
      .result(result), .ext_out(ext_out), .flags_out(flags_out), .wr_dst(wr_dst), .wr_acc(wr_acc), .wr_ext(wr_ext));
   // A half period of 5 ns gives the 100 MHz core clock.
   always #5 clk = ~clk;
   // ****************************************
   // Checking and closing
   // ****************************************
   // An expected value left unknown means the answer is free for that operation, so it is skipped.
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      if ($isunknown(exp)) return;
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // The whole run needs well under a few hundred cycles; 2000 catches a stuck handshake.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         complete_run();
      end
   end
   // ****************************************
   // One operation through the datapath
   // ****************************************
   // Inputs change on the falling edge; the answer is read a half cycle after it lands.
   task automatic run(input logic [2:0] o, input logic w, input logic [15:0] a, input logic [15:0] d,
                      input logic [7:0] c, input logic [7:0] i, input logic [5:0] f, input logic [15:0] er,
                      input logic [15:0] ee, input logic [5:0] ef, input logic [2:0] ew, input int el);
      int n;
      {op, word, acc_in, dst_in, count_in, imm_in, flags_in} = {o, w, a, d, c, i, f};
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      n = 1;
      while (done !== 1'b1 && n < 8) begin
         @(negedge clk);
         n++;
      end
      cmp("latency", el, n);
      cmp("result", er, result);
      cmp("extension", ee, ext_out);
      cmp("flags", ef, flags_out);
      cmp("writes", ew, {wr_dst, wr_acc, wr_ext});
      // A spare cycle keeps the next call from raising start in the step that lowered it.
      @(negedge clk);
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      run(3'h1, 1'b0, 16'h12FF, 16'h00FF, 8'h00, 8'h00, 6'h00, 16'hFE01, 16'h0000, 6'h18, 3'b010, 1);
      run(3'h1, 1'b0, 16'hAB03, 16'hEE04, 8'h00, 8'h00, 6'h3F, 16'h000C, 16'h0000, 6'h27, 3'b010, 1);
      run(3'h1, 1'b1, 16'hFFFF, 16'hFFFF, 8'h00, 8'h00, 6'h00, 16'h0001, 16'hFFFE, 6'h18, 3'b011, 1);
      run(3'h1, 1'b1, 16'h0100, 16'h00FF, 8'h00, 8'h00, 6'h18, 16'hFF00, 16'h0000, 6'h00, 3'b011, 1);
      run(3'h2, 1'b0, 16'h0000, 16'hAB00, 8'h00, 8'h00, 6'h10, 16'h0000, 16'h0000, 6'h05, 3'b100, 1);
      run(3'h2, 1'b0, 16'h0000, 16'h0001, 8'h00, 8'h00, 6'h00, 16'h00FF, 16'h0000, 6'h36, 3'b100, 1);
      run(3'h2, 1'b1, 16'h0000, 16'h8000, 8'h00, 8'h00, 6'h00, 16'h8000, 16'h0000, 6'h1E, 3'b100, 1);
      run(3'h3, 1'b0, 16'h0000, 16'h1234, 8'h00, 8'h00, 6'h2A, 16'h00CB, 16'h0000, 6'h2A, 3'b100, 1);
      run(3'h3, 1'b1, 16'h0000, 16'h1234, 8'h00, 8'h00, 6'h15, 16'hEDCB, 16'h0000, 6'h15, 3'b100, 1);
      run(3'h4, 1'b0, 16'h0000, 16'h00FF, 8'hFF, 8'h00, 6'h2A, 16'h007F, 16'h0000, 6'h2A, 3'b100, 1);
      run(3'h4, 1'b1, 16'h0000, 16'h00FF, 8'hFF, 8'h00, 6'h15, 16'h80FF, 16'h0000, 6'h15, 3'b100, 1);
      run(3'h5, 1'b0, 16'h0000, 16'h0000, 8'h00, 8'h0B, 6'h3F, 16'h0008, 16'h0000, 6'h3F, 3'b100, 1);
      run(3'h5, 1'b1, 16'h0000, 16'h0000, 8'h00, 8'h1C, 6'h00, 16'h1000, 16'h0000, 6'h00, 3'b100, 1);
      run(3'h6, 1'b0, 16'h0000, 16'h0000, 8'h00, 8'h00, 6'h3F, 16'hxxxx, 16'hxxxx, 6'h2F, 3'b000, 1);
      run(3'h6, 1'b0, 16'h0000, 16'h0000, 8'h00, 8'h00, 6'h00, 16'hxxxx, 16'hxxxx, 6'h10, 3'b000, 1);
      run(3'h0, 1'b1, 16'h5555, 16'hAAAA, 8'h0F, 8'h0F, 6'h15, 16'hxxxx, 16'hxxxx, 6'h15, 3'b000, 3);
      run(3'h0, 1'b0, 16'h0000, 16'h0000, 8'h00, 8'h00, 6'h2A, 16'hxxxx, 16'hxxxx, 6'h2A, 3'b000, 3);
      complete_run();
   end
endmodule
